// ### ptcc_pkg.sv
/*
  Shared constants and types of the precision time capture/compare block:
  register offsets, field positions, reset values, timing counts, carriers.
  Assumes nothing beyond a SystemVerilog compiler; no logic lives here.
*/
package ptcc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIME_LSB_NS = 1;
  localparam int NS_PER_CLK = CLK_PERIOD_NS / TIME_LSB_NS;
  localparam int WAVE_RES_NS = 16;
  localparam int WAVE_SHIFT = $clog2(WAVE_RES_NS / TIME_LSB_NS);
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TIME_W = 64;
  localparam int N_EVT = 4;
  localparam int N_WAVE = 4;
  localparam int N_EDGE = 8;
  localparam int SLOT_W = 16;
  localparam int EDGE_IDX_W = $clog2(N_EDGE);
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_TIME_LO = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_TIME_HI = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_EVT_BASE = 8'h20;
  localparam logic [ADDR_W:0] EVT_SPAN = 9'h020;
  localparam int EVT_SHIFT = 3;
  localparam int EVT_HI_BIT = 2;
  localparam logic [ADDR_W-1:0] OFF_PER_BASE = 8'h40;
  localparam logic [ADDR_W:0] PER_SPAN = 9'h010;
  localparam int PER_SHIFT = 2;
  localparam logic [ADDR_W-1:0] OFF_EDGE_BASE = 8'h80;
  localparam logic [ADDR_W:0] EDGE_SPAN = 9'h080;
  localparam int EDGE_PIN_SHIFT = 5;
  localparam int EDGE_ENT_SHIFT = 2;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_WEN_LSB = 4;
  localparam int IRQ_CAP_LSB = 0;
  localparam int IRQ_CMP_LSB = 4;
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] MASK_RST = 32'h0000_0000;
  localparam logic [SLOT_W-1:0] PERIOD_RST = 16'h0001;

  typedef enum logic {EVT_CAPTURE, EVT_COMPARE} ptcc_evt_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ptcc_req_t;

  typedef struct packed {
    logic en;
    logic lvl;
    logic [SLOT_W-1:0] slot;
  } ptcc_edge_t;
endpackage

// ### ptcc_sync2.sv
/*
  Two-flop synchroniser for a vector of independent pin levels.
  Assumes each bit is a slow level; bits are not kept coherent with each other.
*/
`timescale 1ns/1ps
`default_nettype none

module ptcc_sync2 #(
  parameter int W = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // The first stage feeds only the second stage
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

`default_nettype wire

// ### ptcc_wave_chan.sv
/*
  One waveform pin: an edge table of slot/level entries and a slot counter
  that wraps at a programmable period.
  Assumes tick_i pulses once per 16 ns boundary of the shared time base.
*/
`timescale 1ns/1ps
`default_nettype none

module ptcc_wave_chan (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic tick_i,
  input wire logic [ptcc_pkg::SLOT_W-1:0] period_i,
  input wire logic we_i,
  input wire logic [ptcc_pkg::EDGE_IDX_W-1:0] widx_i,
  input wire ptcc_pkg::ptcc_edge_t wdata_i,
  output logic pin_o
);
  import ptcc_pkg::*;

  ptcc_edge_t tbl_q [N_EDGE];
  ptcc_edge_t tbl_d [N_EDGE];
  logic [SLOT_W-1:0] phase_q, phase_d;
  logic lvl_q, lvl_d;

  always_comb begin
    tbl_d = tbl_q;
    phase_d = phase_q;
    lvl_d = lvl_q;
    if (we_i) begin
      tbl_d[widx_i] = wdata_i;
    end
    if (!en_i) begin
      phase_d = '0;
      lvl_d = 1'b0;
    end else if (tick_i) begin
      // Later entries win when two share a slot
      for (int e = 0; e < N_EDGE; e++) begin
        if (tbl_q[e].en && (tbl_q[e].slot == phase_q)) begin
          lvl_d = tbl_q[e].lvl;
        end
      end
      // A period of zero behaves as one slot
      if ((period_i <= 16'h0001) || (phase_q >= period_i - 16'h0001)) begin
        phase_d = '0;
      end else begin
        phase_d = phase_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      for (int e = 0; e < N_EDGE; e++) begin
        tbl_q[e] <= '0;
      end
      phase_q <= '0;
      lvl_q <= 1'b0;
    end else begin
      tbl_q <= tbl_d;
      phase_q <= phase_d;
      lvl_q <= lvl_d;
    end
  end

  assign pin_o = lvl_q;
endmodule

`default_nettype wire

// ### ptcc_top.sv
/*
  Precision time base with four capture/compare event pins, four periodic
  waveform pins, a plain register port and one level interrupt.
  Assumes a 100 MHz clk_sys_i, a synchronous active-low reset and a master
  that issues one-cycle read or write strobes; event pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none


module ptcc_top (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire ptcc_pkg::ptcc_req_t req_i,
  output logic [ptcc_pkg::DATA_W-1:0] rdata_o,
  input wire logic [ptcc_pkg::N_EVT-1:0] evt_pin_i,
  output logic [ptcc_pkg::N_EVT-1:0] evt_pin_o,
  output logic [ptcc_pkg::N_EVT-1:0] evt_pin_oe_o,
  output logic [ptcc_pkg::N_WAVE-1:0] wave_pin_o,
  output logic irq_o
);
  import ptcc_pkg::*;

  function automatic logic in_win(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] base,
    input logic [ADDR_W:0] span
  );
    in_win = ({1'b0, a} >= {1'b0, base}) && ({1'b0, a} < ({1'b0, base} + span));
  endfunction

  function automatic logic [ADDR_W-1:0] win_idx(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] base,
    input int sh
  );
    win_idx = (a - base) >> sh;
  endfunction

  function automatic logic hit(
    input ptcc_req_t r,
    input logic [ADDR_W-1:0] off
  );
    hit = r.addr == off;
  endfunction

  // A target at or below the present time never fires
  function automatic logic reached(
    input logic [TIME_W-1:0] tgt,
    input logic [TIME_W-1:0] now,
    input logic [TIME_W-1:0] nxt
  );
    reached = (tgt > now) && (tgt <= nxt);
  endfunction

  // Time base
  logic [TIME_W-1:0] time_q, time_d;
  logic wave_tick;

  always_comb begin
    // Steps by the clock period in ns, so the count stays true nanoseconds
    time_d = time_q + TIME_W'(NS_PER_CLK);
    // A 10 ns step never jumps two 16 ns boundaries, so one tick is one slot
    wave_tick = time_d[TIME_W-1:WAVE_SHIFT] != time_q[TIME_W-1:WAVE_SHIFT];
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      time_q <= '0;
    end else begin
      time_q <= time_d;
    end
  end

  // Address decode
  logic wr_ctrl, wr_stat, wr_mask;
  logic sel_evt, sel_per, sel_edge;
  logic [ADDR_W-1:0] evt_sel_i, per_sel_i, edge_pin, edge_ent;
  logic evt_hi;
  logic evt_wr_lo, evt_wr_hi;

  always_comb begin
    wr_ctrl = req_i.wr && hit(req_i, OFF_CTRL);
    wr_stat = req_i.wr && hit(req_i, OFF_IRQ_STAT);
    wr_mask = req_i.wr && hit(req_i, OFF_IRQ_MASK);
    sel_evt = in_win(req_i.addr, OFF_EVT_BASE, EVT_SPAN);
    sel_per = in_win(req_i.addr, OFF_PER_BASE, PER_SPAN);
    sel_edge = in_win(req_i.addr, OFF_EDGE_BASE, EDGE_SPAN);
    // Indices come from the byte offset inside each window
    evt_sel_i = win_idx(req_i.addr, OFF_EVT_BASE, EVT_SHIFT);
    per_sel_i = win_idx(req_i.addr, OFF_PER_BASE, PER_SHIFT);
    edge_pin = win_idx(req_i.addr, OFF_EDGE_BASE, EDGE_PIN_SHIFT);
    edge_ent = win_idx(req_i.addr, OFF_EDGE_BASE, EDGE_ENT_SHIFT);
    evt_hi = req_i.addr[EVT_HI_BIT];
    evt_wr_lo = req_i.wr && sel_evt && !evt_hi;
    evt_wr_hi = req_i.wr && sel_evt && evt_hi;
  end

  // Control, mask and period registers
  logic [DATA_W-1:0] ctrl_q, ctrl_d;
  logic [DATA_W-1:0] mask_q, mask_d;
  logic [SLOT_W-1:0] period_q [N_WAVE];
  logic [SLOT_W-1:0] period_d [N_WAVE];
  logic [N_EVT-1:0] is_cmp;
  logic [N_WAVE-1:0] wave_en;

  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    period_d = period_q;
    if (wr_ctrl) begin
      ctrl_d = req_i.wdata;
    end
    if (wr_mask) begin
      mask_d = req_i.wdata;
    end
    if (req_i.wr && sel_per) begin
      period_d[per_sel_i[1:0]] = req_i.wdata[SLOT_W-1:0];
    end
    // Mode bits also choose which event pins are driven
    for (int i = 0; i < N_EVT; i++) begin
      is_cmp[i] = ptcc_evt_mode_t'(ctrl_q[CTRL_MODE_LSB+i]) == EVT_COMPARE;
    end
    wave_en = ctrl_q[CTRL_WEN_LSB +: N_WAVE];
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RST;
      mask_q <= MASK_RST;
      for (int w = 0; w < N_WAVE; w++) begin
        period_q[w] <= PERIOD_RST;
      end
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      period_q <= period_d;
    end
  end

  // Event pins
  logic [N_EVT-1:0] evt_sync;
  logic [N_EVT-1:0] prev_q, prev_d;
  logic [N_EVT-1:0] armed_q, armed_d;
  logic [N_EVT-1:0] lvl_q, lvl_d;
  logic [N_EVT-1:0] goal_q, goal_d;
  logic [N_EVT-1:0] cap_evt, cmp_evt;
  logic [TIME_W-1:0] evt_time_q [N_EVT];
  logic [TIME_W-1:0] evt_time_d [N_EVT];

  ptcc_sync2 #(
    .W(N_EVT)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .d_i(evt_pin_i),
    .q_o(evt_sync)
  );

  always_comb begin
    evt_time_d = evt_time_q;
    armed_d = armed_q;
    lvl_d = lvl_q;
    goal_d = goal_q;
    prev_d = evt_sync;
    for (int i = 0; i < N_EVT; i++) begin
      cap_evt[i] = !is_cmp[i] && evt_sync[i] && !prev_q[i];
      // The step is 10 ns, so a match is the first clock whose time reaches it
      cmp_evt[i] = is_cmp[i] && armed_q[i] && reached(evt_time_q[i], time_q, time_d);
      if (cmp_evt[i]) begin
        lvl_d[i] = goal_q[i];
        armed_d[i] = 1'b0;
      end
      if (!is_cmp[i]) begin
        armed_d[i] = 1'b0;
      end
      if (evt_wr_hi && (evt_sel_i[1:0] == i[1:0])) begin
        // Takes effect at once: load the high word first or a live target may misfire
        evt_time_d[i][TIME_W-1:DATA_W] = req_i.wdata;
      end
      if (evt_wr_lo && (evt_sel_i[1:0] == i[1:0])) begin
        // Writing the low word loads the target, arms it in compare mode and fixes the level to drive
        evt_time_d[i][DATA_W-1:0] = req_i.wdata;
        armed_d[i] = is_cmp[i];
        goal_d[i] = ~lvl_d[i];
      end
      // A hardware capture beats a software write in the same cycle
      if (cap_evt[i]) begin
        evt_time_d[i] = time_q;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prev_q <= '0;
      armed_q <= '0;
      lvl_q <= '0;
      goal_q <= '0;
      for (int i = 0; i < N_EVT; i++) begin
        evt_time_q[i] <= '0;
      end
    end else begin
      prev_q <= prev_d;
      armed_q <= armed_d;
      lvl_q <= lvl_d;
      goal_q <= goal_d;
      evt_time_q <= evt_time_d;
    end
  end

  // Only drive the pin in compare mode; capture mode leaves it to the source
  assign evt_pin_o = lvl_q;
  assign evt_pin_oe_o = is_cmp;

  // Interrupt status
  logic [DATA_W-1:0] stat_q, stat_d;
  logic [DATA_W-1:0] stat_set;
  logic irq_q, irq_d;

  always_comb begin
    stat_set = '0;
    stat_set[IRQ_CAP_LSB +: N_EVT] = cap_evt;
    stat_set[IRQ_CMP_LSB +: N_EVT] = cmp_evt;
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & ~req_i.wdata;
    end
    // Set wins over a clear in the same cycle
    stat_d = stat_d | stat_set;
    // Next values of status and mask, so a mask write takes hold at once
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q <= irq_d;
    end
  end

  assign irq_o = irq_q;

  // Read path
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [DATA_W-1:0] snap_q, snap_d;

  always_comb begin
    rdata_d = '0;
    snap_d = snap_q;
    if (req_i.rd) begin
      unique case (1'b1)
        hit(req_i, OFF_CTRL): begin
          rdata_d = ctrl_q;
        end
        hit(req_i, OFF_IRQ_STAT): begin
          rdata_d = stat_q;
        end
        hit(req_i, OFF_IRQ_MASK): begin
          rdata_d = mask_q;
        end
        hit(req_i, OFF_TIME_LO): begin
          // Freeze the upper half so a low-then-high read is coherent
          rdata_d = time_q[DATA_W-1:0];
          snap_d = time_q[TIME_W-1:DATA_W];
        end
        hit(req_i, OFF_TIME_HI): begin
          rdata_d = snap_q;
        end
        // Event words come straight from the register; a capture between reads can tear them
        sel_evt: begin
          if (evt_hi) begin
            rdata_d = evt_time_q[evt_sel_i[1:0]][TIME_W-1:DATA_W];
          end else begin
            rdata_d = evt_time_q[evt_sel_i[1:0]][DATA_W-1:0];
          end
        end
        sel_per: begin
          rdata_d = {{(DATA_W-SLOT_W){1'b0}}, period_q[per_sel_i[1:0]]};
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
      snap_q <= '0;
    end else begin
      rdata_q <= rdata_d;
      snap_q <= snap_d;
    end
  end

  assign rdata_o = rdata_q;

  // Waveform pins
  ptcc_edge_t edge_wdata;
  logic [N_WAVE-1:0] edge_we;

  always_comb begin
    edge_wdata = req_i.wdata[$bits(ptcc_edge_t)-1:0];
    // One pin's table per window slice; entries read back as zero
    for (int w = 0; w < N_WAVE; w++) begin
      edge_we[w] = req_i.wr && sel_edge && (edge_pin[1:0] == 2'(w));
    end
  end

  for (genvar w = 0; w < N_WAVE; w++) begin : g_wave
    ptcc_wave_chan u_wave (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .en_i(wave_en[w]),
      .tick_i(wave_tick),
      .period_i(period_q[w]),
      .we_i(edge_we[w]),
      .widx_i(edge_ent[EDGE_IDX_W-1:0]),
      .wdata_i(edge_wdata),
      .pin_o(wave_pin_o[w])
    );
  end
endmodule

`default_nettype wire

// ### ptcc_props.sv
/*
  Port-level checker for ptcc_top, bound to every instance.
  Assumes the register map and latencies that ptcc_pkg declares.
*/
`timescale 1ns/1ps
`default_nettype none
module ptcc_props (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire ptcc_pkg::ptcc_req_t req_i,
  input wire logic [ptcc_pkg::DATA_W-1:0] rdata_o,
  input wire logic [ptcc_pkg::N_EVT-1:0] evt_pin_i,
  input wire logic [ptcc_pkg::N_EVT-1:0] evt_pin_o,
  input wire logic [ptcc_pkg::N_EVT-1:0] evt_pin_oe_o,
  input wire logic [ptcc_pkg::N_WAVE-1:0] wave_pin_o,
  input wire logic irq_o
);
  import ptcc_pkg::*;
  logic [3:0] wen_q;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) wen_q <= 4'h0;
    else if (req_i.wr && req_i.addr == OFF_CTRL) wen_q <= req_i.wdata[7:4];
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_rdata_idle;
    !$past(req_i.rd) |-> rdata_o == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_time_step;
    (req_i.rd && req_i.addr == OFF_TIME_LO) ##1 (req_i.rd && req_i.addr == OFF_TIME_LO)
      |=> rdata_o == $past(rdata_o) + 32'h0000_000A;
  endproperty
  a_time_step: assert property (p_time_step) else $error("time step wrong");
  property p_ctrl_oe;
    req_i.wr && req_i.addr == OFF_CTRL |=> evt_pin_oe_o == $past(req_i.wdata[3:0]);
  endproperty
  a_ctrl_oe: assert property (p_ctrl_oe) else $error("pin enable not from mode");
  property p_mask_off;
    req_i.wr && req_i.addr == OFF_IRQ_MASK && req_i.wdata[7:0] == 8'h00 |=> !irq_o;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("masked interrupt seen");
  property p_rst_out;
    $rose(rst_n_i) |-> rdata_o == 32'h0 && evt_pin_o == 4'h0 && evt_pin_oe_o == 4'h0
      && wave_pin_o == 4'h0 && !irq_o;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not clear at reset");
  property p_evt_quiet;
    $changed(evt_pin_o) |->
      ((evt_pin_o ^ $past(evt_pin_o)) & ~(evt_pin_oe_o | $past(evt_pin_oe_o))) == 4'h0;
  endproperty
  a_evt_quiet: assert property (p_evt_quiet) else $error("undriven pin toggled");
  property p_wonly;
    req_i.rd && (req_i.addr[7] || req_i.addr == 8'h14) |=> rdata_o == 32'h0;
  endproperty
  a_wonly: assert property (p_wonly) else $error("write-only place read back");
  property p_wave_off;
    (wave_pin_o & ~$past(wen_q)) == 4'h0;
  endproperty
  a_wave_off: assert property (p_wave_off) else $error("disabled wave pin high");
endmodule
bind ptcc_top ptcc_props u_props (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(req_i),
  .rdata_o(rdata_o), .evt_pin_i(evt_pin_i), .evt_pin_o(evt_pin_o),
  .evt_pin_oe_o(evt_pin_oe_o), .wave_pin_o(wave_pin_o), .irq_o(irq_o));
`default_nettype wire

// ### ptcc_pin_model.sv
/*
  Event sources and loads on the four event pins.
  Assumes fire_i comes from the bench and is held for the pulse length.
*/
`timescale 1ns/1ps
`default_nettype none
module ptcc_pin_model (
  input wire logic clk_sys_i,
  input wire logic [3:0] fire_i,
  input wire logic [3:0] drv_i,
  input wire logic [3:0] oe_i,
  output logic [3:0] pin_o
);
  logic [3:0] src_q = 4'h0;
  // Source edges come off the clock edge, unlike an unrelated external event
  always @(posedge clk_sys_i) src_q <= fire_i;
  assign pin_o = (oe_i & drv_i) | (~oe_i & src_q);
endmodule
`default_nettype wire

// ### tb_top.sv
/*
  Self-checking bench for ptcc_top with pin sources and a queued read scoreboard.
  Assumes ptcc_props and ptcc_pin_model are compiled beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ptcc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  ptcc_req_t req_i = '0;
  logic [31:0] rdata_o;
  logic [3:0] evt_pin_i, evt_pin_o, evt_pin_oe_o, wave_pin_o;
  logic [3:0] fire = 4'h0;
  logic [3:0] wave_d = 4'h0;
  logic irq_o;
  logic rd_seen = 1'b0;
  logic cnt_en = 1'b0;
  logic [31:0] seed = 32'hC23C;
  logic [31:0] last_rd, t0;
  logic [63:0] q[$];
  int errors = 0;
  int n_compared = 0;
  int rise[4];
  int high[4];
  always #5 clk_sys_i = ~clk_sys_i;
  ptcc_top uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(req_i), .rdata_o(rdata_o),
    .evt_pin_i(evt_pin_i), .evt_pin_o(evt_pin_o), .evt_pin_oe_o(evt_pin_oe_o),
    .wave_pin_o(wave_pin_o), .irq_o(irq_o));
  ptcc_pin_model u_pins (.clk_sys_i(clk_sys_i), .fire_i(fire), .drv_i(evt_pin_o),
    .oe_i(evt_pin_oe_o), .pin_o(evt_pin_i));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    req_i <= '{wr: w, rd: r, addr: a, wdata: d};
  endtask
  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 8'h00, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    op(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back({e, m});
    op(1'b0, 1'b1, a, 32'h0);
  endtask
  // Reads whose value is not known ahead; last_rd has landed when this returns
  task automatic get(input logic [7:0] a);
    rd(a, 32'h0, 32'h0);
    idle(3);
  endtask
  always @(posedge clk_sys_i) begin
    logic [63:0] e;
    rd_seen <= req_i.rd;
    wave_d <= wave_pin_o;
    if (rd_seen) begin
      e = q.pop_front();
      last_rd = rdata_o;
      chk(rdata_o & e[31:0], e[63:32] & e[31:0]);
    end
    if (cnt_en) for (int n = 0; n < 4; n++) begin
      rise[n] += int'(wave_pin_o[n] & ~wave_d[n]);
      high[n] += int'(wave_pin_o[n]);
    end
  end
  initial begin
    #100us;
    errors++;
    wrap_up();
  end
  initial begin
    int n;
    logic [3:0] lvl;
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(OFF_CTRL, CTRL_RST, '1);
    rd(OFF_IRQ_STAT, 32'h0, '1);
    rd(OFF_IRQ_MASK, MASK_RST, '1);
    rd(OFF_TIME_HI, 32'h0, '1);
    for (n = 0; n < 4; n++) begin
      rd(8'(OFF_EVT_BASE + 8 * n), 32'h0, '1);
      rd(8'(OFF_PER_BASE + 4 * n), {16'h0, PERIOD_RST}, '1);
    end
    seed = xs(seed);
    wr(8'h14, seed);
    wr(8'h84, seed);
    rd(8'h14, 32'h0, '1);
    rd(8'h84, 32'h0, '1);
    rd(OFF_TIME_LO, 32'h0, 32'h0);
    rd(OFF_TIME_LO, 32'h0, 32'h0);
    get(OFF_TIME_LO);
    t0 = last_rd;
    get(OFF_TIME_LO);
    chk(last_rd - t0, 32'd40);
    seed = xs(seed);
    n = int'(seed[1:0]);
    t0 = last_rd;
    fire[n] <= 1'b1;
    idle(3);
    fire[n] <= 1'b0;
    idle(8);
    get(8'(OFF_EVT_BASE + 8 * n));
    chk(32'(last_rd - t0 > 50 && last_rd - t0 < 200), 32'h1);
    chk(irq_o, 32'h0);
    rd(8'(OFF_EVT_BASE + 8 * n), last_rd, '1);
    rd(OFF_IRQ_STAT, 32'h1 << n, 32'hFF);
    wr(OFF_IRQ_MASK, 32'hFF);
    idle(3);
    chk(irq_o, 32'h1);
    wr(OFF_IRQ_STAT, 32'hFF);
    idle(3);
    chk(irq_o, 32'h0);
    wr(OFF_CTRL, 32'h1 << n);
    idle(2);
    chk(evt_pin_oe_o, 32'h1 << n);
    lvl = evt_pin_o;
    for (int k = 0; k < 2; k++) begin
      get(OFF_TIME_LO);
      wr(8'(OFF_EVT_BASE + 8 * n + 4), 32'h0);
      wr(8'(OFF_EVT_BASE + 8 * n), last_rd + 32'd300);
      idle(20);
      chk(evt_pin_o[n], lvl[n]);
      idle(10);
      chk(evt_pin_o[n], !lvl[n]);
      lvl = evt_pin_o;
    end
    rd(OFF_IRQ_STAT, 32'h10 << n, 32'hF0);
    chk(irq_o, 32'h1);
    wr(OFF_IRQ_MASK, 32'h0);
    idle(2);
    chk(irq_o, 32'h0);
    wr(8'(OFF_EVT_BASE + 8 * n), 32'h5);
    wr(OFF_IRQ_STAT, 32'hFF);
    fire[n] <= 1'b1;
    idle(3);
    fire[n] <= 1'b0;
    idle(30);
    chk(evt_pin_o[n], lvl[n]);
    rd(OFF_IRQ_STAT, 32'h0, 32'hFF);
    for (n = 0; n < 4; n++) begin
      wr(8'(OFF_PER_BASE + 4 * n), 32'(2 * (n + 2)));
      wr(8'(OFF_EDGE_BASE + 32 * n), 32'h0003_0000);
      wr(8'(OFF_EDGE_BASE + 32 * n + 4), 32'(32'h0002_0000 + n + 2));
    end
    wr(OFF_CTRL, 32'hF0);
    idle(100);
    cnt_en <= 1'b1;
    idle(1920);
    cnt_en <= 1'b0;
    idle(2);
    // 19.2 us covers a whole number of periods on every pin
    for (n = 0; n < 4; n++) begin
      chk(32'(rise[n] >= 600 / (n + 2) - 1 && rise[n] <= 600 / (n + 2) + 1), 32'h1);
      chk(32'(high[n] > 930 && high[n] < 990), 32'h1);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
